// ==== rtl/sequencer_stack_entries.sv ====
// Sequencer stack entries nine to eleven with step walker
// Operation
// - Bit 15 of an entry word is the direction: zero read, one write.
// - Return bit zero: step to next entry after the conversion ends; from entry eleven go back to first.
// - Return bit one: go back to first entry after the conversion ends.
// - Bits 7 to 4 pick the converter B channel for the step.
// - Bits 3 to 0 pick the converter A channel for the step.
// - Entry ten resets to 0x5400, its own address, other fields zero.
// - Entry eleven resets to 0x5600, its own address, other fields zero.
`timescale 1ns/1ps
`default_nettype none
module sequencer_stack_entries (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [5:0]  self_address_field,
	input  wire logic [15:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [15:0] regRdata,
	input  wire logic        seqRun,
	input  wire logic        convDone,
	output logic      [1:0]  activeStep,
	output logic             converting,
	output logic      [3:0]  converterAChannel,
	output logic      [3:0]  converterBChannel
);
	////////////////////////////////////////////////////////////////
	logic [15:0] stepNine;
	logic [15:0] stepTen;
	logic [15:0] stepEleven;
	logic        wrNine;
	logic        wrTen;
	logic        wrEleven;
	logic        stackWrapSelect;
	logic [3:0]  selA;
	logic [3:0]  selB;
	logic        accessWrite;
	logic        selfMatch;
	seq_stack_pkg::seq_state_t state;

	// A write lands only when the word asks for write and names the target itself
	assign accessWrite = regWdata[seq_stack_pkg::DIR_BIT];
	assign selfMatch = regWdata[seq_stack_pkg::SELF_HI:seq_stack_pkg::SELF_LO] == self_address_field;
	assign wrNine = regWr && accessWrite && selfMatch && self_address_field == seq_stack_pkg::ADDR_STEP_NINE;
	assign wrTen = regWr && accessWrite && selfMatch && self_address_field == seq_stack_pkg::ADDR_STEP_TEN;
	assign wrEleven = regWr && accessWrite && selfMatch && self_address_field == seq_stack_pkg::ADDR_STEP_ELEVEN;

	seq_stack_entry #(.RESET_VALUE(seq_stack_pkg::RESET_STEP_NINE)) entryNineReg (
		.clk      (clk),
		.rstn     (rstn),
		.writeEn  (wrNine),
		.writeData(regWdata),
		.entry    (stepNine)
	);
	seq_stack_entry #(.RESET_VALUE(seq_stack_pkg::RESET_STEP_TEN)) entryTenReg (
		.clk      (clk),
		.rstn     (rstn),
		.writeEn  (wrTen),
		.writeData(regWdata),
		.entry    (stepTen)
	);
	seq_stack_entry #(.RESET_VALUE(seq_stack_pkg::RESET_STEP_ELEVEN)) entryElevenReg (
		.clk      (clk),
		.rstn     (rstn),
		.writeEn  (wrEleven),
		.writeData(regWdata),
		.entry    (stepEleven)
	);

	////////////////////////////////////////////////////////////////
	// Read data valid only in the cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			regRdata <= 16'h0000;
		end else if (regRd) begin
			unique case (self_address_field)
				seq_stack_pkg::ADDR_STEP_NINE: regRdata <= stepNine;
				seq_stack_pkg::ADDR_STEP_TEN: regRdata <= stepTen;
				seq_stack_pkg::ADDR_STEP_ELEVEN: regRdata <= stepEleven;
				default: regRdata <= 16'h0000;
			endcase
		end else begin
			regRdata <= 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////
	seq_step_select stepSel (
		.step       (activeStep),
		.entryNine  (stepNine),
		.entryTen   (stepTen),
		.entryEleven(stepEleven),
		.wrapSel    (stackWrapSelect),
		.chanA      (selA),
		.chanB      (selB)
	);

	// Step only moves on a finished conversion; the registered channels follow it one cycle later
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= seq_stack_pkg::SEQ_IDLE;
			activeStep <= seq_stack_pkg::STEP_FIRST;
		end else begin
			unique case (state)
				seq_stack_pkg::SEQ_IDLE: begin
					if (seqRun) begin
						state <= seq_stack_pkg::SEQ_CONVERT;
					end
				end
				seq_stack_pkg::SEQ_CONVERT: begin
					if (convDone) begin
						activeStep <= seq_stack_pkg::nextStep(activeStep, stackWrapSelect);
						if (!seqRun) begin
							state <= seq_stack_pkg::SEQ_IDLE;
						end
					end
				end
			endcase
		end
	end

	assign converting = state == seq_stack_pkg::SEQ_CONVERT;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			converterAChannel <= 4'h0;
			converterBChannel <= 4'h0;
		end else begin
			converterAChannel <= selA;
			converterBChannel <= selB;
		end
	end

	////////////////////////////////////////////////////////////////
	// Own pick of the active word, so the channel checks do not lean on the selector
	logic [15:0] checkWord;
	always_comb begin
		if (activeStep == seq_stack_pkg::STEP_FIRST) begin
			checkWord = stepNine;
		end else if (activeStep == seq_stack_pkg::STEP_LAST) begin
			checkWord = stepEleven;
		end else begin
			checkWord = stepTen;
		end
	end

	ten_reset_a: assert property (@(posedge clk)
		$rose(rstn) |-> stepTen == seq_stack_pkg::RESET_STEP_TEN)
		else $error("entry ten reset value wrong");
	eleven_reset_a: assert property (@(posedge clk)
		$rose(rstn) |-> stepEleven == seq_stack_pkg::RESET_STEP_ELEVEN)
		else $error("entry eleven reset value wrong");
	write_dir_a: assert property (@(posedge clk) disable iff (!rstn)
		regWr && !regWdata[seq_stack_pkg::DIR_BIT] |=> $stable(stepTen) && $stable(stepEleven))
		else $error("read-direction word changed an entry");
	read_zero_a: assert property (@(posedge clk) disable iff (!rstn)
		!regRd |=> regRdata == 16'h0000)
		else $error("read data stood without a read");
	self_addr_a: assert property (@(posedge clk) disable iff (!rstn)
		regWr && regWdata[seq_stack_pkg::DIR_BIT] && self_address_field == seq_stack_pkg::ADDR_STEP_TEN
		&& regWdata[seq_stack_pkg::SELF_HI:seq_stack_pkg::SELF_LO] == seq_stack_pkg::ADDR_STEP_TEN
		|=> stepTen == $past(regWdata))
		else $error("addressed write to entry ten lost");
	step_next_a: assert property (@(posedge clk) disable iff (!rstn)
		converting && convDone && !stackWrapSelect && activeStep != seq_stack_pkg::STEP_LAST
		|=> activeStep == $past(activeStep) + 2'h1)
		else $error("sequencer did not advance");
	idle_hold_a: assert property (@(posedge clk) disable iff (!rstn)
		!converting && convDone |=> $stable(activeStep))
		else $error("idle sequencer moved on a done");
	step_wrap_a: assert property (@(posedge clk) disable iff (!rstn)
		converting && convDone && stackWrapSelect |=> activeStep == seq_stack_pkg::STEP_FIRST)
		else $error("sequencer did not return to first");
	chan_b_a: assert property (@(posedge clk) disable iff (!rstn)
		##1 converterBChannel == $past(checkWord[seq_stack_pkg::CHB_HI:seq_stack_pkg::CHB_LO]))
		else $error("converter B channel mismatch");
	chan_a_a: assert property (@(posedge clk) disable iff (!rstn)
		##1 converterAChannel == $past(checkWord[seq_stack_pkg::CHA_HI:seq_stack_pkg::CHA_LO]))
		else $error("converter A channel mismatch");
endmodule
`default_nettype wire

// ==== rtl/seq_stack_pkg.sv ====
// Shared constants for the sequencer stack entry register bank
package seq_stack_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 16;
	localparam int CHAN_W = 4;
	localparam logic [5:0] ADDR_STEP_NINE = 6'h29;
	localparam logic [5:0] ADDR_STEP_TEN = 6'h2a;
	localparam logic [5:0] ADDR_STEP_ELEVEN = 6'h2b;
	localparam int DIR_BIT = 15;
	localparam int SELF_HI = 14;
	localparam int SELF_LO = 9;
	localparam int WRAP_BIT = 8;
	localparam int CHB_HI = 7;
	localparam int CHB_LO = 4;
	localparam int CHA_HI = 3;
	localparam int CHA_LO = 0;
	localparam logic [15:0] RESET_STEP_NINE = 16'h5200;
	localparam logic [15:0] RESET_STEP_TEN = 16'h5400;
	localparam logic [15:0] RESET_STEP_ELEVEN = 16'h5600;
	localparam logic [1:0] STEP_FIRST = 2'h0;
	localparam logic [1:0] STEP_LAST = 2'h2;
	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_CONVERT
	} seq_state_t;
	// Next step index: wrap to first when asked, or after the last entry held here
	function automatic logic [1:0] nextStep(input logic [1:0] cur, input logic wrap);
		if (wrap || cur == STEP_LAST) begin
			return STEP_FIRST;
		end
		return cur + 2'h1;
	endfunction
endpackage

// ==== rtl/seq_stack_entry.sv ====
// One sequence stack entry word with its own reset value
`timescale 1ns/1ps
`default_nettype none
module seq_stack_entry #(
	parameter logic [15:0] RESET_VALUE = 16'h0000
) (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        writeEn,
	input  wire logic [15:0] writeData,
	output logic      [15:0] entry
);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			entry <= RESET_VALUE;
		end else if (writeEn) begin
			entry <= writeData;
		end
	end
endmodule
`default_nettype wire

// ==== rtl/seq_step_select.sv ====
// Picks the field values of the active sequence step
`timescale 1ns/1ps
`default_nettype none
module seq_step_select (
	input  wire logic [1:0]  step,
	input  wire logic [15:0] entryNine,
	input  wire logic [15:0] entryTen,
	input  wire logic [15:0] entryEleven,
	output logic             wrapSel,
	output logic      [3:0]  chanA,
	output logic      [3:0]  chanB
);
	logic [15:0] active;
	always_comb begin
		unique case (step)
			2'h0: active = entryNine;
			2'h1: active = entryTen;
			default: active = entryEleven;
		endcase
		wrapSel = active[seq_stack_pkg::WRAP_BIT];
		chanB = active[seq_stack_pkg::CHB_HI:seq_stack_pkg::CHB_LO];
		chanA = active[seq_stack_pkg::CHA_HI:seq_stack_pkg::CHA_LO];
	end
endmodule
`default_nettype wire

// ==== tb/host_model.sv ====
// Host controller model driving the register port
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input  wire logic        clk,
	input  wire logic [15:0] regRdata,
	output logic      [5:0]  self_address_field,
	output logic      [15:0] regWdata,
	output logic             regWr,
	output logic             regRd
);
	initial begin
		self_address_field = 6'h00;
		regWdata = 16'h0000;
		regWr = 1'b0;
		regRd = 1'b0;
	end
	// One-cycle write; data inverted after so a stale word never looks valid
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		self_address_field <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
		regWdata <= ~d;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [5:0] a, output logic [15:0] q);
		self_address_field <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1;
		q = regRdata;
	endtask
endmodule
`default_nettype wire

// ==== tb/sequencer_stack_entries_tb_top.sv ====
// Self-checking bench for the sequencer stack entry bank
`timescale 1ns/1ps
`default_nettype none
module sequencer_stack_entries_tb_top;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        seqRun = 1'b0;
	logic        convDone = 1'b0;
	logic [5:0]  self_address_field;
	logic [15:0] regWdata;
	logic        regWr;
	logic        regRd;
	logic [15:0] regRdata;
	logic [1:0]  activeStep;
	logic [3:0]  chanA;
	logic [3:0]  chanB;
	logic [15:0] q;
	logic        converting;
	int          nErrors = 0;
	int          checksDone = 0;
	int          seed = 25890;
	int          model [3];
	int          a;
	int          d;
	int          step;
	always #5 clk = ~clk;
	host_model i_host (.clk(clk), .regRdata(regRdata), .self_address_field(self_address_field), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd));
	sequencer_stack_entries i_dut (.clk(clk), .rstn(rstn), .self_address_field(self_address_field), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .seqRun(seqRun), .convDone(convDone),
		.activeStep(activeStep), .converting(converting), .converterAChannel(chanA), .converterBChannel(chanB));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checksDone++;
		if (seen !== exp) begin
			nErrors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic completeRun();
		if (nErrors == 0 && checksDone > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Reset words, then one unmapped place
	task automatic readAll();
		for (int i = 0; i < 4; i++) begin
			i_host.rd(6'h29 + i[5:0], q);
			chk(q, (i < 3) ? model[i][15:0] : 16'h0000);
		end
	endtask
	initial begin
		#200000;
		nErrors++;
		completeRun();
	end
	initial begin
		model = '{32'h5200, 32'h5400, 32'h5600};
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		readAll();
		// Bit 15 as stored is left unchecked: its read-back is not pinned down
		repeat (24) begin
			a = 41 + ($unsigned($random(seed)) % 3);
			d = $random(seed);
			if (d[1]) d[14:9] = a[5:0];
			i_host.wr(a[5:0], d[15:0]);
			if (d[15] && d[14:9] == a[5:0]) model[a - 41] = d;
			i_host.rd(a[5:0], q);
			chk(q[14:0], model[a - 41][14:0]);
		end
		chk(converting, 1'b0);
		seqRun <= 1'b1;
		step = 0;
		repeat (12) begin
			repeat (2) @(posedge clk);
			convDone <= 1'b1;
			@(posedge clk);
			convDone <= 1'b0;
			step = (model[step][8] || step == 2) ? 0 : step + 1;
			repeat (3) @(posedge clk);
			#1;
			chk(activeStep, step[1:0]);
			chk(chanB, model[step][7:4]);
			chk(chanA, model[step][3:0]);
			chk(converting, 1'b1);
		end
		// Run dropped beside the last done: the walk stops, a stray done moves nothing
		seqRun <= 1'b0;
		convDone <= 1'b1;
		@(posedge clk);
		convDone <= 1'b0;
		step = (model[step][8] || step == 2) ? 0 : step + 1;
		repeat (2) @(posedge clk);
		#1;
		chk(converting, 1'b0);
		chk(activeStep, step[1:0]);
		convDone <= 1'b1;
		@(posedge clk);
		convDone <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk(activeStep, step[1:0]);
		// Reset after the run has stopped must bring back every reset word over the written ones
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		model = '{32'h5200, 32'h5400, 32'h5600};
		@(posedge clk);
		readAll();
		chk(activeStep, 2'h0);
		completeRun();
	end
endmodule
`default_nettype wire
